// >>> sim/iop_pin_model.sv
// external devices on the pins, with pull-downs
`timescale 1ns/1ns
module iop_pin_model #(
  parameter int NPINS = 8
) (
  // pins from the block
  input wire logic [NPINS-1:0] pinOut,
  input wire logic [NPINS-1:0] pinOe,
  // bench control
  input wire logic [NPINS-1:0] drvVal,
  input wire logic drvEn,
  // resolved level
  output logic [NPINS-1:0] pinIn
);
  // block wins where it drives, else device level or pull-down
  assign pinIn = (pinOe & pinOut) | (~pinOe & (drvEn ? drvVal : '0));
endmodule : iop_pin_model

// >>> sim/iop_port_pins_properties.sv
// port checker for the pin-sharing port block
`timescale 1ns/1ns
module iop_port_pins_properties #(
  parameter int NPINS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire iop_pkg::iop_bus_s regBus,
  input wire logic [31:0] rdData,
  // pins and link
  input wire logic [NPINS-1:0] pinIn,
  input wire logic [NPINS-1:0] pinOut,
  input wire logic [NPINS-1:0] pinOe,
  input wire logic linkTx,
  input wire logic linkRx
);
  import iop_pkg::*;
  logic [2:0] portEn_r, portOut_r, portOc_r;
  logic linkEn_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // shadow of enable, direction, drive mode and link bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {portEn_r, portOut_r, portOc_r, linkEn_r} <= '0;
    end else if (regBus.wr && regBus.addr[4:0] == 5'h00 && regBus.addr[7:5] < 3'h3) begin
      portEn_r[regBus.addr[6:5]] <= regBus.wdata[0];
      portOut_r[regBus.addr[6:5]] <= regBus.wdata[1];
      portOc_r[regBus.addr[6:5]] <= regBus.wdata[2];
    end else if (regBus.wr && regBus.addr == 8'h80) begin
      linkEn_r <= regBus.wdata[0];
    end
  end
  // one read of the port0 counter
  sequence cntRd;
    regBus.rd && regBus.addr == 8'h10;
  endsequence
  // register port, counter, drive and link relations
  a_rd_quiet: assert property (!regBus.rd |=> rdData == 32'h0)
    else $error("read data not idle");
  a_unmapped_zero: assert property (regBus.rd && regBus.addr == 8'hfc |=> rdData == 32'h0)
    else $error("unmapped read not zero");
  a_count_step: assert property (cntRd ##1 cntRd |=>
    rdData[15:0] == 16'($past(rdData[15:0]) + 16'h1)) else $error("counter step wrong");
  a_input_nodrive: assert property ((portEn_r & portOut_r) == 3'h0 && !linkEn_r
    |=> pinOe == '0) else $error("pins driven with no output port");
  a_narrow_wins: assert property (portEn_r[0] && !portOut_r[0] && !linkEn_r
    |=> !pinOe[0]) else $error("wider port drives narrow port pin");
  a_oc_low: assert property ((portEn_r & portOut_r & ~portOc_r) == 3'h0 && !linkEn_r
    |=> (pinOut & pinOe) == '0) else $error("open collector drives high");
  a_link_out: assert property (linkEn_r |=> pinOe[NPINS-2] && !pinOe[NPINS-1] &&
    pinOut[NPINS-2] == $past(linkTx)) else $error("link transmit pin wrong");
  a_link_in: assert property (linkEn_r [*4] |-> linkRx == $past(pinIn[NPINS-1], 3))
    else $error("link receive wrong");
endmodule : iop_port_pins_properties

bind iop_port_pins iop_port_pins_properties #(.NPINS(NPINS)) iop_port_pins_properties_inst (
  .clk_sys(clk_sys), .resetn(resetn), .regBus(regBus), .rdData(rdData), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe), .linkTx(linkTx), .linkRx(linkRx));

// >>> sim/test_io_port_pin_sharing.sv
// self-checking bench for the pin-sharing port block
`timescale 1ns/1ns
module test_io_port_pin_sharing;
  import iop_pkg::*;
  logic clk_sys, resetn, linkTx, linkRx, drvEn;
  logic [7:0] drvVal, pinIn, pinOut, pinOe;
  logic [31:0] rdData, d, c;
  iop_bus_s regBus;
  int num_errors, n_checks, cyc;
  iop_port_pins iop_port_pins_inst (.clk_sys(clk_sys), .resetn(resetn), .regBus(regBus),
    .rdData(rdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .linkTx(linkTx),
    .linkRx(linkRx));
  iop_pin_model iop_pin_model_inst (.pinOut(pinOut), .pinOe(pinOe), .drvVal(drvVal),
    .drvEn(drvEn), .pinIn(pinIn));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regBus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    regBus.wr <= 1'b0;
  endtask : bus_wr
  task bus_rd(input logic [7:0] a);
    @(posedge clk_sys);
    regBus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    regBus.rd <= 1'b0;
    #1 d = rdData;
  endtask : bus_rd
  task wait_out(input logic [7:0] v);
    #1;
    for (int i = 0; i < 60 && pinOut !== v; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(32'(pinOut), 32'(v));
  endtask : wait_out
  task wait_full(input logic [7:0] a);
    d = 32'h0;
    for (int i = 0; i < 60 && d[0] !== 1'b1; i++) bus_rd(a);
    chk(d & 32'h1, 32'h1);
  endtask : wait_full
  task t_regs();
    bus_rd(8'h00);
    chk(d, 32'h0);
    bus_rd(8'h84);
    chk(d, 32'h1);
    bus_rd(8'hfc);
    chk(d, 32'h0);
    // two back-to-back counter reads one cycle apart
    @(posedge clk_sys);
    regBus <= '{8'h10, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    #1 c = rdData;
    @(posedge clk_sys);
    regBus.rd <= 1'b0;
    #1 d = rdData;
    chk((d - c) & 32'hffff, 32'h1);
  endtask : t_regs
  task t_out_narrow();
    bus_wr(8'h40, 32'h3);
    bus_wr(8'h4c, 32'ha4);
    wait_out(8'ha4);
    chk(32'(pinOe), 32'hff);
    bus_wr(8'h00, 32'h3);
    bus_wr(8'h0c, 32'h80);
    wait_out(8'ha5);
    bus_wr(8'h00, 32'h1);
    bus_wr(8'h40, 32'h7);
    bus_wr(8'h4c, 32'h0e);
    for (int i = 0; i < 60 && pinOe !== 8'hf0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(32'(pinOe), 32'hf0);
    chk(32'(pinOut), 32'h0);
  endtask : t_out_narrow
  task t_in();
    bus_wr(8'h00, 32'h0);
    bus_wr(8'h40, 32'h0);
    drvVal <= 8'h3c;
    drvEn <= 1'b1;
    bus_rd(8'h50);
    c = d;
    bus_wr(8'h40, 32'h1);
    wait_full(8'h58);
    chk(32'(pinOe), 32'h0);
    bus_rd(8'h4c);
    chk(d, 32'h3c);
    bus_rd(8'h54);
    chk(32'((d - c) < 32'h40), 32'h1);
    bus_wr(8'h40, 32'h0);
    // overrun raised while the word sat unread, cleared by writing one
    bus_rd(8'h58);
    chk(d & 32'h2, 32'h2);
    bus_wr(8'h58, 32'h2);
    bus_rd(8'h58);
    chk(d & 32'h2, 32'h0);
    // port0 input waits while pin0 equals its condition value
    bus_wr(8'h00, 32'h10);
    bus_rd(8'h0c);
    bus_wr(8'h00, 32'h11);
    repeat (20) @(posedge clk_sys);
    bus_rd(8'h18);
    chk(d & 32'h1, 32'h0);
    drvVal <= 8'h3d;
    wait_full(8'h18);
    bus_rd(8'h0c);
    chk(d, 32'hff);
    bus_wr(8'h00, 32'h0);
  endtask : t_in
  task t_timed();
    // slow clock block so the next start comes well after the stamp is read
    drvVal <= 8'h00;
    bus_wr(8'h84, 32'h0f);
    bus_wr(8'h20, 32'h48);
    bus_rd(8'h30);
    c = (d + 32'd2) & 32'hffff;
    bus_wr(8'h24, 32'hf);
    bus_wr(8'h28, c);
    bus_wr(8'h20, 32'h49);
    drvVal <= 8'h0f;
    wait_full(8'h38);
    bus_rd(8'h34);
    chk(d, c);
    bus_rd(8'h2c);
    chk(d, 32'hff);
  endtask : t_timed
  task t_clk();
    int sl[3] = '{0, 2, 6};
    int ex[3] = '{40, 10, 0};
    bus_wr(8'h88, 32'h3);
    for (int i = 0; i < 3; i++) begin
      bus_wr(8'h20, 32'(sl[i]) << 6);
      bus_rd(8'h30);
      c = d;
      repeat (38) @(posedge clk_sys);
      bus_rd(8'h30);
      chk((d - c) & 32'hffff, 32'(ex[i]));
    end
  endtask : t_clk
  task t_link();
    bus_wr(8'h80, 32'h1);
    for (int v = 1; v >= 0; v--) begin
      linkTx <= v[0];
      drvVal <= {v[0], 7'h0};
      repeat (5) @(posedge clk_sys);
      #1;
      chk(32'({pinOe[7:6], pinOut[6]}), 32'(2 + v));
      chk(32'(linkRx), 32'(v));
    end
    bus_wr(8'h80, 32'h0);
  endtask : t_link
  // reset, then the scenarios
  initial begin
    regBus = '0;
    resetn = 1'b0;
    linkTx = 1'b0;
    drvEn = 1'b0;
    drvVal = 8'h0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_out_narrow();
    t_in();
    t_timed();
    t_clk();
    t_link();
    close_out();
  end
endmodule : test_io_port_pin_sharing

// >>> verilog/iop_pkg.sv
// types shared by the pin-sharing port block
package iop_pkg;
  typedef enum logic [1:0] {COND_NONE = 2'h0, COND_EQ = 2'h1, COND_NEQ = 2'h2} iop_cond_e;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_WAIT = 3'h2, ST_RUN = 3'h4} iop_st_e;
  typedef struct packed {
    logic [2:0] clkSel;
    logic timed;
    iop_cond_e cond;
    logic openCol;
    logic dirOut;
    logic enable;
  } iop_ctrl_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iop_bus_s;
endpackage : iop_pkg

// >>> verilog/iop_port_pins.sv
// three ports of width 1, 4 and 8 sharing pins with a serial link, six clock blocks
`timescale 1ns/1ns
`include "iop_regs.svh"
// Summary of operation
// RULE1: all pins of one port share one direction bit.
// RULE2: ports drive pins high or low, or sample them, optionally waiting a condition.
// RULE3: every register access completes in a single cycle.
// RULE4: open-collector per port: zero pulls low, one releases the pin.
// RULE5: data passes through a shift register and a transfer register.
// RULE6: each port has a 16-bit counter that can time transfers.
// RULE7: counter readable any time; can delay a transfer to a chosen count.
// RULE8: each transfer stores the counter value as a timestamp.
// RULE9: an enabled link takes its shared pins away from all ports.
// RULE10: a narrower enabled port wins shared pins over a wider one.
// RULE11: unshared pins of the wider port stay with the wider port.
// RULE12: a port always moves its full width, lost pins read zero.
// RULE13: six clock blocks pace the ports.
// RULE14: block zero is the reference tick; others have programmable dividers.
// RULE15: the port counter advances once per tick and wraps.
// RULE16: time compare matches the counter modulo 2^16.
module iop_port_pins #(
  parameter int NPINS = 8,
  parameter int PW0 = 1,
  parameter int PW1 = 4,
  parameter int PW2 = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire iop_pkg::iop_bus_s regBus,
  output logic [31:0] rdData,
  // pins
  input wire logic [NPINS-1:0] pinIn,
  output logic [NPINS-1:0] pinOut,
  output logic [NPINS-1:0] pinOe,
  // link user side
  input wire logic linkTx,
  output logic linkRx
);
  import iop_pkg::*;

  localparam int NP = 3;
  localparam int TW = `IOP_XFER_W;

  logic [NPINS-1:0] pinMeta_r, pinSync_r;
  logic [NPINS-1:0] pinOut_r, pinOe_r, pinOut_nxt, pinOe_nxt;
  logic linkEn_r, linkEn_nxt, linkRx_r, linkRx_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic [7:0] divVal_r [1:5];
  logic [7:0] divVal_nxt [1:5];
  logic [7:0] divCnt_r [1:5];
  logic [7:0] divCnt_nxt [1:5];
  logic [7:0] clkTick;
  logic [NPINS-1:0] own [NP];
  logic [NPINS-1:0] linkOwn;
  iop_ctrl_s ctrl [NP];
  logic [TW-1:0] outVal [NP];
  logic [31:0] portRd [NP];

  // two-stage pin synchroniser
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // clock blocks: block zero ticks every cycle, others divide
  always_comb begin
    clkTick = 8'h00;
    clkTick[0] = 1'b1; // RULE14
    for (int k = 1; k < `IOP_NUM_CLKBLK; k++) begin
      divVal_nxt[k] = divVal_r[k];
      clkTick[k] = (divCnt_r[k] == 8'h00); // RULE13
      divCnt_nxt[k] = clkTick[k] ? divVal_r[k] : 8'(divCnt_r[k] - 8'h01);
      if (regBus.wr && regBus.addr == 8'(`IOP_ADDR_DIV1 + 4 * (k - 1))) begin
        divVal_nxt[k] = regBus.wdata[7:0]; // RULE14
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int k = 1; k < `IOP_NUM_CLKBLK; k++) begin
        divVal_r[k] <= `IOP_DIV_RST;
        divCnt_r[k] <= 8'h00;
      end
    end else begin
      for (int k = 1; k < `IOP_NUM_CLKBLK; k++) begin
        divVal_r[k] <= divVal_nxt[k];
        divCnt_r[k] <= divCnt_nxt[k];
      end
    end
  end

  // pin ownership: link first, then narrowest enabled port
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      linkOwn[i] = linkEn_r && (i >= NPINS - 2); // RULE9
      own[0][i] = !linkOwn[i] && ctrl[0].enable && (i < PW0); // RULE10
      own[1][i] = !linkOwn[i] && !own[0][i] && ctrl[1].enable && (i < PW1); // RULE10
      own[2][i] = !linkOwn[i] && !own[0][i] && !own[1][i] && ctrl[2].enable
                  && (i < PW2); // RULE11
    end
  end

  // pin drive, link, global registers and read mux
  always_comb begin
    pinOut_nxt = '0;
    pinOe_nxt = '0;
    linkEn_nxt = linkEn_r;
    linkRx_nxt = linkRx_r;
    rdData_nxt = 32'h0000_0000;
    for (int i = 0; i < NPINS; i++) begin
      for (int p = 0; p < NP; p++) begin
        if (own[p][i] && ctrl[p].dirOut) begin
          if (ctrl[p].openCol) begin
            pinOe_nxt[i] = !outVal[p][i]; // RULE4
          end else begin
            pinOut_nxt[i] = outVal[p][i]; // RULE2
            pinOe_nxt[i] = 1'b1;
          end
        end
      end
    end
    if (linkEn_r) begin
      pinOut_nxt[NPINS-2] = linkTx; // RULE9
      pinOe_nxt[NPINS-2] = 1'b1;
      linkRx_nxt = pinSync_r[NPINS-1];
    end
    if (regBus.wr && regBus.addr == `IOP_ADDR_LINK) begin
      linkEn_nxt = regBus.wdata[0];
    end
    if (regBus.rd) begin
      if (!regBus.addr[7]) begin
        for (int p = 0; p < NP; p++) begin
          if (regBus.addr[6:5] == 2'(p)) begin
            rdData_nxt = portRd[p]; // RULE3
          end
        end
      end else if (regBus.addr == `IOP_ADDR_LINK) begin
        rdData_nxt = {31'h0, linkEn_r};
      end else if (regBus.addr >= `IOP_ADDR_DIV1 && regBus.addr <= `IOP_ADDR_DIV5
                   && regBus.addr[1:0] == 2'h0) begin
        rdData_nxt = {24'h0, divVal_r[3'(regBus.addr[4:2]) + 3'h0]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinOut_r <= '0;
      pinOe_r <= '0;
      linkEn_r <= 1'b0;
      linkRx_r <= 1'b0;
      rdData_r <= 32'h0000_0000;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
      linkEn_r <= linkEn_nxt;
      linkRx_r <= linkRx_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;
  assign linkRx = linkRx_r;
  assign rdData = rdData_r;

  // one engine per port
  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam int W = (p == 0) ? PW0 : (p == 1) ? PW1 : PW2;
    localparam logic [3:0] SLOTS = 4'(TW / W);
    localparam logic [TW-1:0] WMASK = TW'((1 << W) - 1);
    iop_ctrl_s ctrl_r, ctrl_nxt;
    iop_st_e st_r, st_nxt;
    logic [TW-1:0] cond_r, cond_nxt, xfer_r, xfer_nxt, shift_r, shift_nxt;
    logic [TW-1:0] outVal_r, outVal_nxt, sample, base;
    logic [15:0] time_r, time_nxt, cnt_r, cnt_nxt, stamp_r, stamp_nxt;
    logic [3:0] slot_r, slot_nxt, left;
    logic armed_r, armed_nxt, full_r, full_nxt, ovr_r, ovr_nxt;
    logic tick, wrHere, rdHere, condOk, timeOk, start, step;

    assign ctrl[p] = ctrl_r;
    assign outVal[p] = outVal_r;
    assign wrHere = regBus.wr && !regBus.addr[7] && regBus.addr[6:5] == 2'(p);
    assign rdHere = regBus.rd && !regBus.addr[7] && regBus.addr[6:5] == 2'(p);

    // readback of this port
    always_comb begin
      case (regBus.addr[4:0])
        `IOP_OFF_CTRL: portRd[p] = {23'h0, ctrl_r};
        `IOP_OFF_COND: portRd[p] = {24'h0, cond_r};
        `IOP_OFF_TIME: portRd[p] = {16'h0, time_r};
        `IOP_OFF_DATA: portRd[p] = {24'h0, xfer_r};
        `IOP_OFF_COUNT: portRd[p] = {16'h0, cnt_r}; // RULE7
        `IOP_OFF_STAMP: portRd[p] = {16'h0, stamp_r}; // RULE8
        `IOP_OFF_STAT: portRd[p] = {30'h0, ovr_r, full_r};
        default: portRd[p] = 32'h0000_0000;
      endcase
    end

    // serialiser, transfer register, counter and timing
    always_comb begin
      ctrl_nxt = ctrl_r;
      st_nxt = st_r;
      cond_nxt = cond_r;
      xfer_nxt = xfer_r;
      shift_nxt = shift_r;
      outVal_nxt = outVal_r;
      time_nxt = time_r;
      stamp_nxt = stamp_r;
      slot_nxt = slot_r;
      armed_nxt = armed_r;
      full_nxt = full_r;
      ovr_nxt = ovr_r;
      tick = clkTick[ctrl_r.clkSel];
      cnt_nxt = tick ? 16'(cnt_r + 16'h0001) : cnt_r; // RULE15
      sample = pinSync_r[TW-1:0] & own[p][TW-1:0] & WMASK; // RULE12
      condOk = (ctrl_r.cond == COND_NONE) || (ctrl_r.cond == COND_EQ && sample == cond_r)
               || (ctrl_r.cond == COND_NEQ && sample != cond_r); // RULE2
      timeOk = !armed_r || (cnt_r == time_r); // RULE16
      start = 1'b0;
      // software side; hardware events below take precedence, but a same-cycle data write keeps full set and a control write is applied last
      if (wrHere) begin
        case (regBus.addr[4:0])
          `IOP_OFF_COND: cond_nxt = regBus.wdata[TW-1:0];
          `IOP_OFF_TIME: begin
            time_nxt = regBus.wdata[15:0]; // RULE7
            armed_nxt = 1'b1;
          end
          `IOP_OFF_DATA: begin
            xfer_nxt = regBus.wdata[TW-1:0]; // RULE5
            full_nxt = ctrl_r.dirOut;
          end
          `IOP_OFF_STAT: if (regBus.wdata[`IOP_STAT_OVR]) ovr_nxt = 1'b0;
          default: ;
        endcase
      end
      if (rdHere && regBus.addr[4:0] == `IOP_OFF_DATA && !ctrl_r.dirOut) begin
        full_nxt = 1'b0;
      end
      case (st_r)
        ST_IDLE: if (ctrl_r.enable && (!ctrl_r.dirOut || full_r)) st_nxt = ST_WAIT;
        ST_WAIT: start = tick && timeOk && (ctrl_r.dirOut || condOk) // RULE6
                         && (!ctrl_r.dirOut || full_r);
        ST_RUN: ;
        default: st_nxt = ST_IDLE;
      endcase
      step = start || (st_r == ST_RUN && tick);
      base = start ? (ctrl_r.dirOut ? xfer_r : '0) : shift_r;
      left = start ? 4'(SLOTS - 4'h1) : 4'(slot_r - 4'h1);
      if (start) begin
        stamp_nxt = cnt_r; // RULE8
        armed_nxt = 1'b0;
        // a new word written in the same cycle keeps full set
        if (ctrl_r.dirOut && !(wrHere && regBus.addr[4:0] == `IOP_OFF_DATA)) begin
          full_nxt = 1'b0;
        end
      end
      if (step) begin
        slot_nxt = left;
        st_nxt = (left == 4'h0) ? ST_IDLE : ST_RUN;
        if (ctrl_r.dirOut) begin
          outVal_nxt = base & WMASK; // RULE5
          shift_nxt = base >> W;
        end else begin
          shift_nxt = (base >> W) | TW'(sample << (TW - W)); // RULE12
          if (left == 4'h0) begin
            if (full_r && full_nxt) ovr_nxt = 1'b1;
            else begin
              xfer_nxt = shift_nxt;
              full_nxt = 1'b1;
            end
          end
        end
      end
      if (wrHere && regBus.addr[4:0] == `IOP_OFF_CTRL) begin
        ctrl_nxt = iop_ctrl_s'(regBus.wdata[8:0]); // RULE1
        st_nxt = ST_IDLE;
      end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        ctrl_r <= iop_ctrl_s'(`IOP_CTRL_RST);
        st_r <= ST_IDLE;
        cond_r <= '0;
        xfer_r <= '0;
        shift_r <= '0;
        outVal_r <= '0;
        time_r <= 16'h0000;
        cnt_r <= 16'h0000;
        stamp_r <= 16'h0000;
        slot_r <= 4'h0;
        armed_r <= 1'b0;
        full_r <= 1'b0;
        ovr_r <= 1'b0;
      end else begin
        ctrl_r <= ctrl_nxt;
        st_r <= st_nxt;
        cond_r <= cond_nxt;
        xfer_r <= xfer_nxt;
        shift_r <= shift_nxt;
        outVal_r <= outVal_nxt;
        time_r <= time_nxt;
        cnt_r <= cnt_nxt;
        stamp_r <= stamp_nxt;
        slot_r <= slot_nxt;
        armed_r <= armed_nxt;
        full_r <= full_nxt;
        ovr_r <= ovr_nxt;
      end
    end
  end
endmodule : iop_port_pins

// >>> verilog/iop_regs.svh
// register offsets, field positions and reset values of the pin-sharing port block
`ifndef IOP_REGS_SVH
`define IOP_REGS_SVH
`define IOP_PORT_STRIDE_SH 5
`define IOP_OFF_CTRL 5'h00
`define IOP_OFF_COND 5'h04
`define IOP_OFF_TIME 5'h08
`define IOP_OFF_DATA 5'h0c
`define IOP_OFF_COUNT 5'h10
`define IOP_OFF_STAMP 5'h14
`define IOP_OFF_STAT 5'h18
`define IOP_ADDR_LINK 8'h80
`define IOP_ADDR_DIV1 8'h84
`define IOP_ADDR_DIV5 8'h94
`define IOP_STAT_FULL 0
`define IOP_STAT_OVR 1
`define IOP_CTRL_RST 9'h000
`define IOP_DIV_RST 8'h01
`define IOP_NUM_CLKBLK 6
`define IOP_XFER_W 8
`endif
